// File: design/i2cms_cfg.svh
// Register offsets, field positions and reset values of the two-wire controller
`ifndef I2CMS_CFG_SVH
`define I2CMS_CFG_SVH
`define I2CMS_OFF_CON 8'h00
`define I2CMS_OFF_STAT 8'h04
`define I2CMS_OFF_MSK 8'h08
`define I2CMS_OFF_TX 8'h0c
`define I2CMS_OFF_RX 8'h10
`define I2CMS_OFF_ADDR 8'h14
`define I2CMS_OFF_BRG 8'h18
`define I2CMS_CON_RST 16'h1000
`define I2CMS_B_EN 15
`define I2CMS_B_REL 12
`define I2CMS_B_ALL 11
`define I2CMS_B_A10 10
`define I2CMS_B_GENERAL_CALL_ENABLE 7
`define I2CMS_B_STRETCH_ENABLE 6
`define I2CMS_B_ACK_DATA_VALUE 5
`define I2CMS_B_ACK_SEQUENCE_GO 4
`define I2CMS_B_MASTER_RECEIVE_GO 3
`define I2CMS_B_PEN 2
`define I2CMS_B_REPEATED_START_REQUEST 1
`define I2CMS_B_SEN 0
`define I2CMS_S_ACK 15
`define I2CMS_S_TRS 14
`define I2CMS_S_BCL 10
`define I2CMS_S_GC 9
`define I2CMS_S_A10 8
`define I2CMS_S_WCOL 7
`define I2CMS_S_OV 6
`define I2CMS_S_DA 5
`define I2CMS_S_P 4
`define I2CMS_S_S 3
`define I2CMS_S_RW 2
`define I2CMS_S_RBF 1
`define I2CMS_S_TBF 0
`define I2CMS_STAT_SWC 16'h04c0
`define I2CMS_MSK_W 16'h03ff
`define I2CMS_GC_ADDR 8'h00
`define I2CMS_A10_HDR 5'h1e
`define I2CMS_BRG_RST 16'h0010
`define I2CMS_RESP_OK 2'h0
`define I2CMS_RESP_ERR 2'h2
`endif

// File: design/i2cms_pkg.sv
// Types shared by the two-wire controller
package i2cms_pkg;
	typedef enum logic [3:0] {
		MS_IDLE, MS_START, MS_RSTART, MS_STOP, MS_TX, MS_TXACK, MS_RX, MS_ACK,
		SL_ADDR, SL_ADDR_ACK, SL_RX, SL_RX_ACK, SL_TX, SL_TX_ACK, SL_WAIT
	} i2cms_state_e;
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start_det;
		logic stop_det;
		logic scl_lvl;
		logic sda_lvl;
	} i2cms_line_s;
	typedef struct packed {
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		logic scl_q;
		logic sda_q;
		i2cms_line_s line;
	} i2cms_mon_s;
endpackage

// File: design/i2cms_line_mon.sv
// Pin synchroniser and start, stop and clock-edge finder
`timescale 1ns/10ps
`default_nettype none
module i2cms_line_mon
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scl_in,
	input wire logic sda_in,
	output var i2cms_pkg::i2cms_line_s line
);
	i2cms_pkg::i2cms_mon_s s_q;
	i2cms_pkg::i2cms_mon_s s_d;
	always_comb
	begin
		s_d = s_q;
		s_d.scl_sync = {s_q.scl_sync[1:0], scl_in};
		s_d.sda_sync = {s_q.sda_sync[1:0], sda_in};
		// Accept a change once stages two and three agree
		if (s_q.scl_sync[1] == s_q.scl_sync[2])
			s_d.scl_q = s_q.scl_sync[2];
		if (s_q.sda_sync[1] == s_q.sda_sync[2])
			s_d.sda_q = s_q.sda_sync[2];
		s_d.line.scl_rise = s_d.scl_q & ~s_q.scl_q;
		s_d.line.scl_fall = ~s_d.scl_q & s_q.scl_q;
		s_d.line.start_det = s_q.scl_q & s_d.scl_q & s_q.sda_q & ~s_d.sda_q;
		s_d.line.stop_det = s_q.scl_q & s_d.scl_q & ~s_q.sda_q & s_d.sda_q;
		s_d.line.scl_lvl = s_d.scl_q;
		s_d.line.sda_lvl = s_d.sda_q;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= {3'h7, 3'h7, 1'b1, 1'b1, 6'h03};
		else
			s_q <= s_d;
	end
	assign line = s_q.line;
	AST_START_NOT_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
		!(line.start_det && line.stop_det)) else $error("start and stop together");
endmodule
`default_nettype wire

// File: design/i2cms_top.sv
// Two-wire master and slave controller with AXI4-Lite registers
// Overview of operation
// - Completed byte moves to receive buffer with one pulse.
// - Enable bit hands pins to controller; clear returns them.
// - Slave stretch via clock release; hardware clears at tx start, rx end.
// - Accept-all mode acknowledges every address except 00h while general call is disabled.
// - Width bit selects 10-bit or 7-bit own-address compare.
// - General call raises event only when enabled.
// - Ack sequence drives ack data bit; cleared when done.
// - Receive go clocks one byte; cleared after eighth bit.
// - Start, repeated start, stop requests; each cleared when done.
// - Master transmit records slave ack as status.
// - Transmit active set at start, cleared after slave ack.
// - Bus collision flag set in master op, sticky till cleared.
// - General call seen set on match, cleared on stop.
// - Ten-bit match set on second byte, cleared on stop.
// - Transmit write while busy rejected, sets write collision.
// - Byte into full receive buffer sets overflow.
// - Data-or-address cleared on address match, set on data.
// - Stop-seen and start-seen follow the last condition.
// - Direction flag shows read or write after address.
// - Receive full set on load, cleared on software read.
// - Transmit full set on write, cleared when sent.
// - Mask bits exclude address bits from compare.
`timescale 1ns/10ps
`default_nettype none
`include "i2cms_cfg.svh"
module i2cms_top
#(
	parameter int HALF_MIN = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic pins_owned,
	output logic rx_event
);
	typedef struct packed {
		logic awv; logic [7:0] awa; logic wv; logic [31:0] wd; logic [3:0] ws;
		logic bv; logic [1:0] br; logic rv; logic [31:0] rd; logic [1:0] rr;
		logic arr;
		logic [15:0] con; logic [15:0] stat; logic [9:0] msk; logic [9:0] own;
		logic [15:0] brg; logic [7:0] tx; logic [7:0] rx; logic [7:0] sh;
		i2cms_pkg::i2cms_state_e st; logic [3:0] bitc; logic [1:0] ph;
		logic [15:0] cnt; logic sda_lo; logic scl_lo; logic abyte; logic hi10;
		logic pulse;
	} i2cms_state_s;
	i2cms_state_s q;
	i2cms_state_s d;
	i2cms_pkg::i2cms_line_s ln;
	logic [9:0] cmp_addr;
	logic adr_hit;
	logic tick;
	logic [15:0] sw_rd;
	if (HALF_MIN < 1)
	begin : g_half_min_bad
		$error("HALF_MIN must be at least one");
	end
	i2cms_line_mon u_mon (.aclk(aclk), .aresetn(aresetn), .scl_in(scl_in),
		.sda_in(sda_in), .line(ln));
	assign tick = (q.cnt == 16'h0000);
	always_comb
	begin
		// 7-bit address is first byte bits 7:1; 10-bit is header bits plus second byte
		if (q.con[`I2CMS_B_A10])
			cmp_addr = q.hi10 ? {q.abyte ? q.own[9:8] : 2'h0, q.sh} :
				{q.sh[2:1], 8'h00};
		else
			cmp_addr = {3'h0, q.sh[7:1]};
		adr_hit = (((cmp_addr ^ q.own) & ~q.msk) == 10'h000) | q.con[`I2CMS_B_ALL];
		if (q.con[`I2CMS_B_A10] && !q.hi10)
			adr_hit = (q.sh[7:3] == `I2CMS_A10_HDR) &&
				(((q.sh[2:1] ^ q.own[9:8]) & ~q.msk[9:8]) == 2'h0) || q.con[`I2CMS_B_ALL];
	end
	always_comb
	begin
		sw_rd = 16'h0000;
		case (q.arr ? q.awa : s_axi_araddr)
			`I2CMS_OFF_CON: sw_rd = q.con;
			`I2CMS_OFF_STAT: sw_rd = q.stat;
			`I2CMS_OFF_MSK: sw_rd = {6'h00, q.msk};
			`I2CMS_OFF_TX: sw_rd = {8'h00, q.tx};
			`I2CMS_OFF_RX: sw_rd = {8'h00, q.rx};
			`I2CMS_OFF_ADDR: sw_rd = {6'h00, q.own};
			`I2CMS_OFF_BRG: sw_rd = q.brg;
			default: sw_rd = 16'h0000;
		endcase
	end
	always_comb
	begin
		d = q;
		d.pulse = 1'b0;
		d.arr = 1'b0;
		// Write channels may arrive in either order
		if (s_axi_awvalid && !q.awv)
		begin
			d.awv = 1'b1;
			d.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.wv)
		begin
			d.wv = 1'b1;
			d.wd = s_axi_wdata;
			d.ws = s_axi_wstrb;
		end
		if (q.bv && s_axi_bready)
			d.bv = 1'b0;
		if (q.rv && s_axi_rready)
			d.rv = 1'b0;
		if (s_axi_arvalid && !q.rv && !q.arr)
		begin
			d.rv = 1'b1;
			d.rd = {16'h0000, sw_rd};
			d.rr = `I2CMS_RESP_OK;
			if (s_axi_araddr > `I2CMS_OFF_BRG || s_axi_araddr[1:0] != 2'h0)
				d.rr = `I2CMS_RESP_ERR;
			if (s_axi_araddr == `I2CMS_OFF_RX)
				d.stat[`I2CMS_S_RBF] = 1'b0;
		end
		// Bit-time divider
		d.cnt = tick ? (q.brg < 16'(HALF_MIN) ? 16'(HALF_MIN) : q.brg) : q.cnt - 16'h0001;
		// Bus events common to master and slave
		if (ln.start_det)
		begin
			d.stat[`I2CMS_S_S] = 1'b1;
			d.stat[`I2CMS_S_P] = 1'b0;
			if (q.st == i2cms_pkg::MS_IDLE || q.st == i2cms_pkg::SL_WAIT)
			begin
				d.st = i2cms_pkg::SL_ADDR;
				d.bitc = 4'h0;
				d.abyte = 1'b0;
			end
		end
		if (ln.stop_det)
		begin
			d.stat[`I2CMS_S_P] = 1'b1;
			d.stat[`I2CMS_S_S] = 1'b0;
			d.stat[`I2CMS_S_GC] = 1'b0;
			d.stat[`I2CMS_S_A10] = 1'b0;
			d.hi10 = 1'b0;
			if (q.st >= i2cms_pkg::SL_ADDR)
				d.st = i2cms_pkg::MS_IDLE;
		end
		// Master releases data but line reads low: lost arbitration
		if (q.st >= i2cms_pkg::MS_START && q.st <= i2cms_pkg::MS_ACK && !q.sda_lo &&
			q.scl_lo == 1'b0 && ln.scl_rise && !ln.sda_lvl && q.st != i2cms_pkg::MS_RX)
		begin
			d.stat[`I2CMS_S_BCL] = 1'b1;
			d.st = i2cms_pkg::MS_IDLE;
			d.con[4:0] = 5'h00;
			d.stat[`I2CMS_S_TRS] = 1'b0;
			d.sda_lo = 1'b0;
			d.scl_lo = 1'b0;
		end
		else
		case (q.st)
			i2cms_pkg::MS_IDLE:
			begin
				d.sda_lo = 1'b0;
				d.scl_lo = 1'b0;
				d.ph = 2'h0;
				if (q.con[`I2CMS_B_SEN]) d.st = i2cms_pkg::MS_START;
				else if (q.con[`I2CMS_B_REPEATED_START_REQUEST]) d.st = i2cms_pkg::MS_RSTART;
				else if (q.con[`I2CMS_B_PEN]) d.st = i2cms_pkg::MS_STOP;
				else if (q.con[`I2CMS_B_MASTER_RECEIVE_GO]) d.st = i2cms_pkg::MS_RX;
				else if (q.con[`I2CMS_B_ACK_SEQUENCE_GO]) d.st = i2cms_pkg::MS_ACK;
				d.bitc = 4'h0;
			end
			i2cms_pkg::MS_START, i2cms_pkg::MS_RSTART, i2cms_pkg::MS_STOP:
			if (tick)
			begin
				d.ph = q.ph + 2'h1;
				case (q.ph)
					2'h0:
					begin
						d.scl_lo = 1'b0;
						d.sda_lo = q.st == i2cms_pkg::MS_STOP;
					end
					2'h1: d.sda_lo = q.st != i2cms_pkg::MS_STOP;
					2'h2:
					begin
						d.scl_lo = q.st != i2cms_pkg::MS_STOP;
						d.con[`I2CMS_B_SEN] = 1'b0;
						d.con[`I2CMS_B_REPEATED_START_REQUEST] = 1'b0;
						d.con[`I2CMS_B_PEN] = 1'b0;
						d.st = i2cms_pkg::MS_IDLE;
						if (q.st != i2cms_pkg::MS_STOP) d.st = i2cms_pkg::SL_WAIT;
					end
					default: d.ph = 2'h0;
				endcase
			end
			i2cms_pkg::MS_TX, i2cms_pkg::MS_RX, i2cms_pkg::MS_ACK, i2cms_pkg::MS_TXACK:
			if (tick)
			begin
				d.ph = q.ph + 2'h1;
				if (q.ph == 2'h0)
				begin
					d.scl_lo = 1'b1;
					d.sda_lo = q.st == i2cms_pkg::MS_TX ? ~q.sh[7] :
						q.st == i2cms_pkg::MS_ACK ? ~q.con[`I2CMS_B_ACK_DATA_VALUE] : 1'b0;
				end
				else if (q.ph == 2'h1)
					d.scl_lo = 1'b0;
				else if (q.ph == 2'h2 && ln.scl_lvl)
				begin
					d.ph = 2'h0;
					d.scl_lo = 1'b1;
					d.sh = {q.sh[6:0], ln.sda_lvl};
					d.bitc = q.bitc + 4'h1;
					if (q.st == i2cms_pkg::MS_TXACK)
					begin
						d.stat[`I2CMS_S_ACK] = ln.sda_lvl;
						d.stat[`I2CMS_S_TRS] = 1'b0;
						d.stat[`I2CMS_S_TBF] = 1'b0;
						d.st = i2cms_pkg::SL_WAIT;
						d.sda_lo = 1'b0;
					end
					else if (q.st == i2cms_pkg::MS_ACK)
					begin
						d.con[`I2CMS_B_ACK_SEQUENCE_GO] = 1'b0;
						d.st = i2cms_pkg::SL_WAIT;
						d.sda_lo = 1'b0;
					end
					else if (q.bitc == 4'h7)
					begin
						d.bitc = 4'h0;
						d.sda_lo = 1'b0;
						d.st = i2cms_pkg::SL_WAIT;
						if (q.st == i2cms_pkg::MS_TX)
							d.st = i2cms_pkg::MS_TXACK;
						else
						begin
							d.con[`I2CMS_B_MASTER_RECEIVE_GO] = 1'b0;
							d.pulse = 1'b1;
							if (q.stat[`I2CMS_S_RBF])
								d.stat[`I2CMS_S_OV] = 1'b1;
							else
							begin
								d.rx = {q.sh[6:0], ln.sda_lvl};
								d.stat[`I2CMS_S_RBF] = 1'b1;
							end
						end
					end
				end
				else if (q.ph == 2'h3)
					d.ph = 2'h2;
			end
			i2cms_pkg::SL_WAIT:
			begin
				// Master holds clock low between phases; slave idles here too
				if (q.con[4:0] != 5'h00 && q.scl_lo)
					d.st = i2cms_pkg::MS_IDLE;
				if (q.stat[`I2CMS_S_TBF] && q.scl_lo && q.con[4:0] == 5'h00)
				begin
					d.st = i2cms_pkg::MS_TX;
					d.sh = q.tx;
					d.ph = 2'h0;
					d.bitc = 4'h0;
					d.stat[`I2CMS_S_TRS] = 1'b1;
				end
			end
			i2cms_pkg::SL_ADDR, i2cms_pkg::SL_RX:
			if (ln.scl_rise)
			begin
				d.sh = {q.sh[6:0], ln.sda_lvl};
				d.bitc = q.bitc + 4'h1;
				if (q.bitc == 4'h7)
					d.st = q.st == i2cms_pkg::SL_ADDR ? i2cms_pkg::SL_ADDR_ACK :
						i2cms_pkg::SL_RX_ACK;
			end
			i2cms_pkg::SL_ADDR_ACK:
			if (ln.scl_fall)
			begin
				d.bitc = 4'h0;
				d.st = i2cms_pkg::SL_WAIT;
				if (q.sh == `I2CMS_GC_ADDR && q.con[`I2CMS_B_GENERAL_CALL_ENABLE])
				begin
					d.stat[`I2CMS_S_GC] = 1'b1;
					d.pulse = 1'b1;
					// The call address lands in the receive buffer like any byte
					if (q.stat[`I2CMS_S_RBF])
						d.stat[`I2CMS_S_OV] = 1'b1;
					else
					begin
						d.rx = q.sh;
						d.stat[`I2CMS_S_RBF] = 1'b1;
					end
					d.sda_lo = 1'b1;
					d.st = i2cms_pkg::SL_RX_ACK;
				end
				else if (adr_hit && q.sh != `I2CMS_GC_ADDR)
				begin
					d.sda_lo = 1'b1;
					d.stat[`I2CMS_S_DA] = 1'b0;
					d.stat[`I2CMS_S_RW] = q.sh[0];
					d.abyte = 1'b1;
					if (q.con[`I2CMS_B_A10] && !q.hi10 && !q.sh[0])
						d.hi10 = 1'b1;
					else if (q.con[`I2CMS_B_A10] && q.hi10 && !q.stat[`I2CMS_S_A10])
						d.stat[`I2CMS_S_A10] = 1'b1;
					d.st = q.sh[0] ? i2cms_pkg::SL_TX : i2cms_pkg::SL_RX_ACK;
					if (q.sh[0])
					begin
						d.con[`I2CMS_B_REL] = 1'b0;
						d.sh = q.tx;
					end
				end
			end
			i2cms_pkg::SL_RX_ACK:
			if (q.sda_lo && ln.scl_fall)
			begin
				d.sda_lo = 1'b0;
				d.st = i2cms_pkg::SL_RX;
				if (q.hi10 && !q.stat[`I2CMS_S_A10])
					d.st = i2cms_pkg::SL_ADDR;
			end
			else if (!q.sda_lo && ln.scl_fall)
			begin
				d.bitc = 4'h0;
				d.stat[`I2CMS_S_DA] = 1'b1;
				d.pulse = 1'b1;
				if (q.stat[`I2CMS_S_RBF])
					d.stat[`I2CMS_S_OV] = 1'b1;
				else
				begin
					d.rx = q.sh;
					d.stat[`I2CMS_S_RBF] = 1'b1;
				end
				if (q.con[`I2CMS_B_STRETCH_ENABLE])
					d.con[`I2CMS_B_REL] = 1'b0;
				d.sda_lo = 1'b1;
			end
			i2cms_pkg::SL_TX:
			if (ln.scl_fall || (q.bitc == 4'h0 && !q.scl_lo))
			begin
				d.sda_lo = ~q.sh[7];
				d.sh = {q.sh[6:0], 1'b1};
				d.bitc = q.bitc + 4'h1;
				if (q.bitc == 4'h8)
				begin
					d.sda_lo = 1'b0;
					d.stat[`I2CMS_S_TBF] = 1'b0;
					d.st = i2cms_pkg::SL_TX_ACK;
				end
			end
			i2cms_pkg::SL_TX_ACK:
			if (ln.scl_rise)
			begin
				d.bitc = 4'h0;
				d.st = ln.sda_lvl ? i2cms_pkg::SL_WAIT : i2cms_pkg::SL_TX;
				d.sh = q.tx;
				if (!ln.sda_lvl)
					d.con[`I2CMS_B_REL] = 1'b0;
			end
			default: d.st = i2cms_pkg::MS_IDLE;
		endcase
		// Slave stretch holds clock while release bit is low
		// Wait state also parks the master, whose clock hold must survive here
		if (q.st >= i2cms_pkg::SL_ADDR && q.st != i2cms_pkg::SL_WAIT)
			d.scl_lo = ~q.con[`I2CMS_B_REL] & ~ln.scl_lvl;
		// Register write once both address and data are held
		if (q.awv && q.wv && !q.bv)
		begin
			d.awv = 1'b0;
			d.wv = 1'b0;
			d.bv = 1'b1;
			d.br = `I2CMS_RESP_OK;
			if (q.ws[1:0] == 2'h3)
			case (q.awa)
				`I2CMS_OFF_CON:
				begin
					d.con = q.wd[15:0] & 16'hbfff;
					// Release takes the written value whether or not stretching is enabled
					if (!q.con[`I2CMS_B_STRETCH_ENABLE] && !q.wd[`I2CMS_B_REL])
						d.con[`I2CMS_B_REL] = q.con[`I2CMS_B_REL] & d.con[`I2CMS_B_REL];
					d.con[4:0] = q.wd[4:0] | d.con[4:0];
				end
				`I2CMS_OFF_STAT:
				begin
					// Hardware set wins over software clear
					d.stat = (d.stat & ~`I2CMS_STAT_SWC) |
						(d.stat & q.wd[15:0] & `I2CMS_STAT_SWC) |
						(d.stat & ~q.stat & `I2CMS_STAT_SWC);
				end
				`I2CMS_OFF_MSK: d.msk = q.wd[9:0];
				`I2CMS_OFF_TX:
					if (q.stat[`I2CMS_S_TBF] || q.stat[`I2CMS_S_TRS] ||
						q.con[4:0] != 5'h00)
						d.stat[`I2CMS_S_WCOL] = 1'b1;
					else
					begin
						d.tx = q.wd[7:0];
						d.stat[`I2CMS_S_TBF] = 1'b1;
					end
				`I2CMS_OFF_ADDR: d.own = q.wd[9:0];
				`I2CMS_OFF_BRG: d.brg = q.wd[15:0];
				default: d.br = `I2CMS_RESP_ERR;
			endcase
		end
		if (!q.con[`I2CMS_B_EN])
		begin
			d.st = i2cms_pkg::MS_IDLE;
			d.sda_lo = 1'b0;
			d.scl_lo = 1'b0;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.con <= `I2CMS_CON_RST;
			q.brg <= `I2CMS_BRG_RST;
		end
		else
			q <= d;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			pins_owned <= 1'b0;
		end
		else
		begin
			scl_oe <= d.con[`I2CMS_B_EN] & d.scl_lo;
			sda_oe <= d.con[`I2CMS_B_EN] & d.sda_lo;
			pins_owned <= d.con[`I2CMS_B_EN];
		end
	end
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign rx_event = q.pulse;
	assign s_axi_awready = ~q.awv;
	assign s_axi_wready = ~q.wv;
	assign s_axi_bvalid = q.bv;
	assign s_axi_bresp = q.br;
	assign s_axi_arready = ~q.rv;
	assign s_axi_rvalid = q.rv;
	assign s_axi_rdata = q.rd;
	assign s_axi_rresp = q.rr;
	AST_RBF_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(q.pulse) && !$past(q.stat[`I2CMS_S_RBF]) |-> q.stat[`I2CMS_S_RBF])
		else $error("receive full not set");
	AST_OWN_PINS: assert property (@(posedge aclk) disable iff (!aresetn)
		!pins_owned |-> !scl_oe && !sda_oe) else $error("pins driven while off");
	AST_BCL_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
		q.stat[`I2CMS_S_BCL] && !(q.awv && q.wv) |=> q.stat[`I2CMS_S_BCL])
		else $error("collision flag dropped");
	AST_STOP_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
		ln.stop_det |=> !q.stat[`I2CMS_S_GC] && !q.stat[`I2CMS_S_A10] && q.stat[`I2CMS_S_P])
		else $error("stop did not clear flags");
	AST_START_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		ln.start_det |=> q.stat[`I2CMS_S_S] && !q.stat[`I2CMS_S_P])
		else $error("start flag wrong");
	AST_PULSE_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_event |=> !rx_event) else $error("receive pulse too long");
	AST_OV: assert property (@(posedge aclk) disable iff (!aresetn)
		q.pulse && $past(q.stat[`I2CMS_S_RBF]) && $past(q.stat[`I2CMS_S_DA]) |->
		q.stat[`I2CMS_S_OV] || q.stat[`I2CMS_S_GC]) else $error("overflow missed");
	AST_TRS_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(q.stat[`I2CMS_S_TRS]) && !q.stat[`I2CMS_S_BCL] |-> $past(q.st) ==
		i2cms_pkg::MS_TXACK) else $error("transmit active cleared early");
endmodule
`default_nettype wire

// File: verification/i2cms_peer.sv
// Behavioural far-side bus master driving the shared clock and data lines
`timescale 1ns/10ps
`default_nettype none
module i2cms_peer
(
	input wire logic scl,
	input wire logic sda,
	output logic scl_dn,
	output logic sda_dn
);
	initial
	begin
		scl_dn = 1'b0;
		sda_dn = 1'b0;
	end
	// Data moves mid-low; clock release waits out any stretching
	task automatic put_bit(input logic b);
		sda_dn = ~b;
		#40;
		scl_dn = 1'b0;
		wait (scl === 1'b1);
		#80;
		scl_dn = 1'b1;
		#40;
	endtask
	task automatic start_cond;
		sda_dn = 1'b1;
		#80;
		scl_dn = 1'b1;
		#40;
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		sda_dn = 1'b0;
		#80;
		scl_dn = 1'b0;
		wait (scl === 1'b1);
		#60;
		ack = sda;
		#20;
		scl_dn = 1'b1;
		#40;
	endtask
	task automatic stop_cond;
		sda_dn = 1'b1;
		#40;
		scl_dn = 1'b0;
		wait (scl === 1'b1);
		#80;
		sda_dn = 1'b0;
		#180;
	endtask
endmodule
`default_nettype wire

// File: verification/i2cms_top_tb.sv
// Self-checking bench of the two-wire controller
`timescale 1ns/10ps
`default_nettype none
module i2cms_top_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic scl_out, scl_oe, sda_out, sda_oe, pins_owned, rx_event, scl_dn, sda_dn, ack;
	wire scl_w = ~(scl_oe | scl_dn);
	wire sda_w = ~(sda_oe | sda_dn);
	int n_mismatch, checked, cyc, n_ev;
	i2cms_top #(.HALF_MIN(4)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .pins_owned(pins_owned), .rx_event(rx_event));
	i2cms_peer peer (.scl(scl_w), .sda(sda_w), .scl_dn(scl_dn), .sda_dn(sda_dn));
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cyc++;
		if (rx_event === 1'b1)
			n_ev++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			complete_run;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("mismatches %0d of %0d checks", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		rsp = bresp;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		rv = rdata;
		rsp = rresp;
	endtask
	task automatic probe(input logic [7:0] b);
		peer.start_cond;
		peer.send_byte(b, ack);
	endtask
	task automatic t_regs;
		axr(8'h00);
		chk(rv, 32'h1000);
		axr(8'h04);
		chk(rv, 32'h0);
		axr(8'h08);
		chk(rv, 32'h0);
		axw(8'h08, 32'hffff);
		axr(8'h08);
		chk(rv, 32'h3ff);
		axr(8'h40);
		chk(rsp, 2'h2);
		axw(8'h14, 32'h2a);
		axw(8'h08, 32'h0);
		axw(8'h00, 32'h9000);
		repeat (2) @(posedge aclk);
		chk(pins_owned, 1'b1);
	endtask
	task automatic t_slave;
		probe(8'h54);
		chk(ack, 1'b0);
		axr(8'h04);
		chk(rv & 32'h3c, 32'h08);
		axr(8'h10);
		n_ev = 0;
		peer.send_byte(8'ha5, ack);
		chk(n_ev, 1);
		axr(8'h04);
		chk(rv & 32'h62, 32'h22);
		peer.send_byte(8'h3c, ack);
		axr(8'h04);
		chk(rv & 32'h40, 32'h40);
		axr(8'h10);
		chk(rv, 32'ha5);
		axr(8'h04);
		chk(rv & 32'h2, 32'h0);
		axw(8'h04, 32'h0);
		axr(8'h04);
		chk(rv & 32'h40, 32'h0);
		peer.stop_cond;
		axr(8'h04);
		chk(rv & 32'h18, 32'h10);
	endtask
	task automatic t_addr;
		axw(8'h08, 32'h1);
		probe(8'h56);
		chk(ack, 1'b0);
		peer.stop_cond;
		probe(8'h50);
		chk(ack, 1'b1);
		peer.stop_cond;
		axw(8'h08, 32'h0);
		probe(8'h00);
		chk(ack, 1'b1);
		peer.stop_cond;
		axw(8'h00, 32'h9800);
		probe(8'h66);
		chk(ack, 1'b0);
		peer.stop_cond;
		axw(8'h00, 32'h9080);
		probe(8'h00);
		chk(ack, 1'b0);
		axr(8'h04);
		chk(rv & 32'h200, 32'h200);
		peer.stop_cond;
		axr(8'h04);
		chk(rv & 32'h200, 32'h0);
		axw(8'h00, 32'h9400);
		probe(8'hf0);
		peer.send_byte(8'h2a, ack);
		chk(ack, 1'b0);
		axr(8'h04);
		chk(rv & 32'h100, 32'h100);
		peer.stop_cond;
		axr(8'h04);
		chk(rv & 32'h100, 32'h0);
	endtask
	task automatic t_master;
		axw(8'h00, 32'h9001);
		do
			axr(8'h00);
		while (rv[0] !== 1'b0);
		chk(sda_w, 1'b0);
		axr(8'h04);
		chk(rv & 32'h18, 32'h08);
		// Nobody answers the byte, so the slave ack reads as NACK
		axw(8'h0c, 32'h55);
		axw(8'h0c, 32'haa);
		axr(8'h04);
		chk(rv & 32'h4081, 32'h4081);
		axw(8'h04, 32'h0);
		do
			axr(8'h04);
		while (rv[0] !== 1'b0);
		chk(rv & 32'hc081, 32'h8000);
		axw(8'h00, 32'h9004);
		do
			axr(8'h00);
		while (rv[2] !== 1'b0);
		chk({scl_w, sda_w}, 2'h3);
		axr(8'h04);
		chk(rv & 32'h18, 32'h10);
	endtask
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_slave;
		t_addr;
		t_master;
		axw(8'h00, 32'h1000);
		repeat (2) @(posedge aclk);
		chk({pins_owned, scl_oe, sda_oe}, 3'h0);
		complete_run;
	end
endmodule
`default_nettype wire
